// file: design/dce_defs.vh
// Constants for the drawing engine command and control block
`ifndef DCE_DEFS_VH
`define DCE_DEFS_VH
`define DCE_ADDR_W 24
`define DCE_OFS_DEST 24'h100004
`define DCE_OFS_DIM 24'h100008
`define DCE_OFS_CTRL 24'h10000c
`define DCE_RST_WORD 32'h00000000
`define DCE_DEST_MASK 32'h9fffffff
`define DCE_DIM_MASK 32'h1fffffff
`define DCE_DEST_WRAP 31
`define DCE_DEST_X 27:16
`define DCE_DEST_Y 11:0
`define DCE_DIM_X 28:16
`define DCE_DIM_Y 15:0
`define DCE_CTL_START 31
`define DCE_CTL_PAT_COLOR 30
`define DCE_CTL_UPDATE_X 29
`define DCE_CTL_QUICK 28
`define DCE_CTL_DIR 27
`define DCE_CTL_MAJOR_Y 26
`define DCE_CTL_XNEG 25
`define DCE_CTL_YNEG 24
`define DCE_CTL_STRETCH 23
`define DCE_CTL_HOST_MONO 22
`define DCE_CTL_LAST_PIX 21
`define DCE_CTL_CMD 20:16
`define DCE_CTL_BINARY 15
`define DCE_CTL_BIN_PAT 14
`define DCE_CTL_PACK 13:12
`define DCE_CTL_REPEAT 11
`define DCE_CTL_TMATCH 10
`define DCE_CTL_TDEST 9
`define DCE_CTL_TEN 8
`define DCE_CTL_ROP 7:0
`define DCE_CMD_BLOCK_COPY 5'h00
`define DCE_CMD_RECT_FILL 5'h01
`define DCE_CMD_DETILE 5'h02
`define DCE_CMD_TRAP_FILL 5'h03
`define DCE_CMD_ALPHA 5'h04
`define DCE_CMD_RLE_STRIP 5'h05
`define DCE_CMD_SHORT_STROKE 5'h06
`define DCE_CMD_LINE 5'h07
`define DCE_CMD_HOST_WRITE 5'h08
`define DCE_CMD_HOST_READ 5'h09
`define DCE_CMD_HOST_WRITE_UP 5'h0a
`define DCE_CMD_ROTATE 5'h0b
`define DCE_CMD_FONT 5'h0c
`define DCE_CMD_TEXTURE 5'h0f
`define DCE_ANG_0 2'h0
`define DCE_ANG_270 2'h1
`define DCE_ANG_90 2'h2
`define DCE_ANG_180 2'h3
`define DCE_PACK_NONE 2'h0
`define DCE_PACK_8 2'h1
`define DCE_PACK_16 2'h2
`define DCE_ST_IDLE 2'h0
`define DCE_ST_RUN 2'h1
`define DCE_ST_DONE 2'h2
`endif

// file: design/dce_raster_op.v
// Raster operation unit: ternary and binary pixel combiners
`timescale 1ns/100ps
`include "dce_defs.vh"
module dce_raster_op (
  input wire [31:0] pat_i,
  input wire [31:0] src_i,
  input wire [31:0] dst_i,
  input wire [7:0] code_i,
  input wire binary_i,
  input wire bin_src_pat_i,
  output reg [31:0] res_o
);
  integer i;
  reg bin_src;

  always @* begin
    res_o = 32'h00000000;
    bin_src = 1'b0;
    for (i = 0; i < 32; i = i + 1) begin
      if (binary_i) begin
        bin_src = bin_src_pat_i ? pat_i[i] : src_i[i];
        res_o[i] = code_i[{bin_src, dst_i[i]}];
      end else begin
        res_o[i] = code_i[{pat_i[i], src_i[i], dst_i[i]}];
      end
    end
  end
endmodule

// file: design/dce_engine.v
// Drawing engine command registers and operation sequencer
// Operation
// - Destination bit 31 enables destination wrap
// - Destination X field: coordinate, low address, start
// - Destination Y field: coordinate, high address, start
// - Dimension X field: width, vector or horizontal length
// - Dimension Y field: height, error term, other length
// - Control bit 31 starts; zero means stopped
// - Quick start begins on dimension write
// - Bit 30 selects mono or colour pattern
// - Bit 29 updates destination X after operation
// - Bit 27 selects left or right direction
// - Line major axis and step signs
// - Bit 23 enables vertical stretch
// - Bit 22 selects colour or mono host data
// - Bit 21 controls drawing final line pixel
// - Five-bit command field decode
// - Binary or ternary op, binary source select
// - Mono packing field decode
// - Repeat rotate restarts at each vertical sync that finds the sequencer idle
// - Transparency enable, source and match sense
// - All 256 ternary codes; mono pattern
// - Rotate angle from step bits
`timescale 1ns/100ps
`include "dce_defs.vh"
module dce_engine (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [23:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_rd_i,
  output wire [31:0] reg_rdata_o,
  input wire vsync_pulse_i,
  input wire [13:0] line_k1_i,
  input wire [13:0] line_k2_i,
  input wire [31:0] pat_pix_i,
  input wire [31:0] src_pix_i,
  input wire [31:0] dst_pix_i,
  input wire src_match_i,
  input wire dst_match_i,
  input wire pix_ready_i,
  output wire pix_valid_o,
  output wire pix_we_o,
  output wire [11:0] pix_x_o,
  output wire [11:0] pix_y_o,
  output wire [31:0] pix_data_o,
  output wire [11:0] cur_x_o,
  output wire [11:0] cur_y_o,
  output wire busy_o,
  output wire [4:0] command_o,
  output wire wrap_enable_o,
  output wire pattern_color_o,
  output wire vertical_stretch_enable_o,
  output wire host_mono_o,
  output wire [1:0] mono_pack_o,
  output wire [1:0] rotate_angle_o
);
  reg [31:0] dest_reg;
  reg [31:0] dim_reg;
  reg [31:0] ctrl_reg;
  reg [31:0] rdata_reg;
  reg [1:0] state_reg;
  reg [11:0] x_reg;
  reg [11:0] y_reg;
  reg [12:0] xcnt_reg;
  reg [15:0] ycnt_reg;
  reg [15:0] err_reg;
  reg pv_reg;
  reg pwe_reg;
  reg [11:0] px_reg;
  reg [11:0] py_reg;
  reg [31:0] pdata_reg;
  wire [31:0] rop_res;
  wire [4:0] cmd;
  wire is_line;
  wire is_stroke;
  wire xstep_neg;
  wire ystep_neg;
  wire last_pix;
  wire transparent;
  wire go_write;
  wire go_quick;
  wire go_repeat;
  wire start;
  reg [11:0] nx;
  reg [11:0] ny;
  reg [15:0] nerr;
  reg finish;
  // Sequencer states
  localparam [1:0] ST_IDLE = `DCE_ST_IDLE;
  localparam [1:0] ST_RUN = `DCE_ST_RUN;
  localparam [1:0] ST_DONE = `DCE_ST_DONE;

  function [11:0] step12;
    input [11:0] v;
    input neg;
    begin
      step12 = neg ? v - 12'h001 : v + 12'h001;
    end
  endfunction

  function sel;
    input [23:0] a;
    input [23:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  assign cmd = ctrl_reg[`DCE_CTL_CMD];
  assign is_line = (cmd == `DCE_CMD_LINE);
  assign is_stroke = (cmd == `DCE_CMD_SHORT_STROKE);
  // Block ops walk by direction bit, lines by the step bits
  assign xstep_neg = (is_line | is_stroke) ? ctrl_reg[`DCE_CTL_XNEG]
                                           : ctrl_reg[`DCE_CTL_DIR];
  assign ystep_neg = (is_line | is_stroke) ? ctrl_reg[`DCE_CTL_YNEG]
                                           : (cmd == `DCE_CMD_HOST_WRITE_UP);
  assign last_pix = (xcnt_reg == 13'h0001) & (ycnt_reg == 16'h0001 | is_line | is_stroke);
  // Match sense picks which pixels get dropped
  assign transparent = ctrl_reg[`DCE_CTL_TEN] &
    ((ctrl_reg[`DCE_CTL_TDEST] ? dst_match_i : src_match_i)
     == ctrl_reg[`DCE_CTL_TMATCH]);

  dce_raster_op u_rop (
    .pat_i(pat_pix_i),
    .src_i(src_pix_i),
    .dst_i(dst_pix_i),
    .code_i(ctrl_reg[`DCE_CTL_ROP]),
    .binary_i(ctrl_reg[`DCE_CTL_BINARY]),
    .bin_src_pat_i(ctrl_reg[`DCE_CTL_BIN_PAT]),
    .res_o(rop_res)
  );

  // Writes to the command registers are ignored while busy
  assign go_write = reg_wr_i & sel(reg_addr_i, `DCE_OFS_CTRL) &
                    reg_wdata_i[`DCE_CTL_START] & (state_reg == ST_IDLE);
  assign go_quick = reg_wr_i & sel(reg_addr_i, `DCE_OFS_DIM) &
                    ctrl_reg[`DCE_CTL_QUICK] & (state_reg == ST_IDLE);
  assign go_repeat = vsync_pulse_i & ctrl_reg[`DCE_CTL_REPEAT] &
                     (cmd == `DCE_CMD_ROTATE) & (state_reg == ST_IDLE);
  assign start = go_write | go_quick | go_repeat;

  // Done cycle clears status and, when bit 29 is set, moves destination X
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dest_reg <= `DCE_RST_WORD;
      dim_reg <= `DCE_RST_WORD;
      ctrl_reg <= `DCE_RST_WORD;
    end else begin
      if (reg_wr_i & (state_reg == ST_IDLE)) begin
        if (sel(reg_addr_i, `DCE_OFS_DEST))
          dest_reg <= reg_wdata_i & `DCE_DEST_MASK;
        if (sel(reg_addr_i, `DCE_OFS_DIM))
          dim_reg <= reg_wdata_i & `DCE_DIM_MASK;
        if (sel(reg_addr_i, `DCE_OFS_CTRL))
          ctrl_reg <= reg_wdata_i;
      end
      if (go_quick | go_repeat)
        ctrl_reg[`DCE_CTL_START] <= 1'b1;
      if (state_reg == ST_DONE) begin
        ctrl_reg[`DCE_CTL_START] <= 1'b0;
        if (ctrl_reg[`DCE_CTL_UPDATE_X])
          dest_reg[`DCE_DEST_X] <= x_reg;
      end
    end
  end

  // Read data held until the next read
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_reg <= `DCE_RST_WORD;
    end else if (reg_rd_i) begin
      if (sel(reg_addr_i, `DCE_OFS_DEST))
        rdata_reg <= dest_reg;
      else if (sel(reg_addr_i, `DCE_OFS_DIM))
        rdata_reg <= dim_reg;
      else if (sel(reg_addr_i, `DCE_OFS_CTRL))
        rdata_reg <= ctrl_reg;
      else
        rdata_reg <= `DCE_RST_WORD;
    end
  end

  // Next position for the current walk
  always @* begin
    nx = x_reg;
    ny = y_reg;
    nerr = err_reg;
    finish = last_pix;
    if (is_line) begin
      if (ctrl_reg[`DCE_CTL_MAJOR_Y]) begin
        ny = step12(y_reg, ystep_neg);
        if (!err_reg[15])
          nx = step12(x_reg, xstep_neg);
      end else begin
        nx = step12(x_reg, xstep_neg);
        if (!err_reg[15])
          ny = step12(y_reg, ystep_neg);
      end
      // Error term sign picks K2 or K1 increment
      nerr = err_reg[15] ? err_reg + {{2{line_k1_i[13]}}, line_k1_i}
                         : err_reg + {{2{line_k2_i[13]}}, line_k2_i};
    end else if (is_stroke) begin
      if (ctrl_reg[`DCE_CTL_MAJOR_Y])
        ny = step12(y_reg, ystep_neg);
      else
        nx = step12(x_reg, xstep_neg);
    end else if (xcnt_reg == 13'h0001) begin
      nx = dest_reg[`DCE_DEST_X];
      ny = step12(y_reg, ystep_neg);
    end else begin
      nx = step12(x_reg, xstep_neg);
    end
  end

  // One pixel per ready cycle; zero sizes finish at once
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      x_reg <= 12'h000;
      y_reg <= 12'h000;
      xcnt_reg <= 13'h0000;
      ycnt_reg <= 16'h0000;
      err_reg <= 16'h0000;
      pv_reg <= 1'b0;
      pwe_reg <= 1'b0;
      px_reg <= 12'h000;
      py_reg <= 12'h000;
      pdata_reg <= 32'h00000000;
    end else begin
      pv_reg <= 1'b0;
      pwe_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            x_reg <= dest_reg[`DCE_DEST_X];
            y_reg <= dest_reg[`DCE_DEST_Y];
            xcnt_reg <= go_quick ? reg_wdata_i[`DCE_DIM_X] : dim_reg[`DCE_DIM_X];
            ycnt_reg <= go_quick ? reg_wdata_i[`DCE_DIM_Y] : dim_reg[`DCE_DIM_Y];
            err_reg <= go_quick ? reg_wdata_i[`DCE_DIM_Y] : dim_reg[`DCE_DIM_Y];
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (xcnt_reg == 13'h0000 ||
              (ycnt_reg == 16'h0000 && !is_line && !is_stroke)) begin
            state_reg <= ST_DONE;
          end else if (pix_ready_i) begin
            pv_reg <= 1'b1;
            // Line end pixel kept only when asked
            pwe_reg <= !transparent &
                       !(is_line & last_pix & !ctrl_reg[`DCE_CTL_LAST_PIX]);
            px_reg <= x_reg;
            py_reg <= y_reg;
            pdata_reg <= rop_res;
            x_reg <= nx;
            y_reg <= ny;
            err_reg <= nerr;
            if (finish) begin
              state_reg <= ST_DONE;
            end else if (xcnt_reg == 13'h0001) begin
              xcnt_reg <= dim_reg[`DCE_DIM_X];
              ycnt_reg <= ycnt_reg - 16'h0001;
            end else begin
              xcnt_reg <= xcnt_reg - 13'h0001;
            end
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign pix_valid_o = pv_reg;
  assign pix_we_o = pwe_reg;
  assign pix_x_o = px_reg;
  assign pix_y_o = py_reg;
  assign pix_data_o = pdata_reg;
  assign cur_x_o = x_reg;
  assign cur_y_o = y_reg;
  assign busy_o = ctrl_reg[`DCE_CTL_START];
  assign command_o = cmd;
  assign wrap_enable_o = dest_reg[`DCE_DEST_WRAP];
  assign pattern_color_o = ctrl_reg[`DCE_CTL_PAT_COLOR];
  assign vertical_stretch_enable_o = ctrl_reg[`DCE_CTL_STRETCH];
  assign host_mono_o = ctrl_reg[`DCE_CTL_HOST_MONO];
  assign mono_pack_o = ctrl_reg[`DCE_CTL_PACK];
  // Rotate angle uses the step bits directly: 00=0,01=270,10=90,11=180
  assign rotate_angle_o = (cmd == `DCE_CMD_ROTATE) ?
    {ctrl_reg[`DCE_CTL_XNEG], ctrl_reg[`DCE_CTL_YNEG]} : `DCE_ANG_0;
endmodule

// file: tb/dce_pix_model.sv
// Pixel datapath model: operands per position, ready that may stall
`timescale 1ns/100ps
module dce_pix_model (
  input wire clk_sys_i,
  input wire slow_i,
  input wire [11:0] cur_x_i,
  input wire [11:0] cur_y_i,
  output reg pix_ready_o,
  output wire [31:0] pat_o,
  output wire [31:0] src_o,
  output wire [31:0] dst_o,
  output wire src_match_o,
  output wire dst_match_o
);
  reg [7:0] lfsr_reg;
  assign pat_o = {cur_x_i, cur_y_i, 8'h5a};
  assign src_o = {cur_y_i, 8'h3c, cur_x_i};
  assign dst_o = ~pat_o ^ {8'hc3, cur_y_i, cur_x_i};
  assign src_match_o = cur_x_i[0];
  assign dst_match_o = cur_y_i[0];
  initial begin
    lfsr_reg = 8'h5b;
    pix_ready_o = 1'b0;
  end
  // Fixed stall pattern keeps runs repeatable
  always @(negedge clk_sys_i) begin
    lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    pix_ready_o <= !slow_i || lfsr_reg[0];
  end
endmodule

// file: tb/dce_engine_properties.sv
// Checker: register reads, start paths and pixel timing
`timescale 1ns/100ps
module dce_engine_properties (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [23:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire vsync_pulse_i,
  input wire pix_valid_o,
  input wire busy_o,
  input wire [4:0] command_o,
  input wire [1:0] rotate_angle_o
);
  reg busy_reg;
  reg quick_reg;
  reg repeat_reg;
  reg [1:0] calm_reg;
  wire idle = !busy_o && !busy_reg;
  wire wr_ctl = reg_wr_i && reg_addr_i == 24'h10000c && !busy_o;
  wire wr_dim = reg_wr_i && reg_addr_i == 24'h100008 && !busy_o;
  // Shadow of control bits arming the automatic starts
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      busy_reg <= 1'b0;
      quick_reg <= 1'b0;
      repeat_reg <= 1'b0;
      calm_reg <= 2'h0;
    end else begin
      busy_reg <= busy_o;
      calm_reg <= (reg_wr_i || vsync_pulse_i) ? 2'h0 : calm_reg + {1'b0, calm_reg != 2'h3};
      if (wr_ctl) begin
        quick_reg <= reg_wdata_i[28];
        repeat_reg <= reg_wdata_i[11];
      end
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_dim_rsv; reg_rd_i && reg_addr_i == 24'h100008 |=> reg_rdata_o[31:29] == 3'h0;
  endproperty
  a_dim_rsv: assert property (p_dim_rsv) else $error("dim reserved bits set");
  property p_dst_rsv; reg_rd_i && reg_addr_i == 24'h100004 |=> reg_rdata_o[30:29] == 2'h0;
  endproperty
  a_dst_rsv: assert property (p_dst_rsv) else $error("dest reserved bits set");
  property p_start; wr_ctl && reg_wdata_i[31] |-> ##[1:2] busy_o; endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_quick; wr_dim && quick_reg && reg_wdata_i[28:16] != 13'h0
    && reg_wdata_i[15:0] != 16'h0 |-> ##[1:2] busy_o; endproperty
  a_quick: assert property (p_quick) else $error("quick start ignored");
  property p_vsync; vsync_pulse_i && idle && repeat_reg && command_o == 5'h0b
    |-> ##[1:2] busy_o; endproperty
  a_vsync: assert property (p_vsync) else $error("repeat rotate not restarted");
  property p_stopped; reg_rd_i && reg_addr_i == 24'h10000c && idle && calm_reg == 2'h3
    |=> !reg_rdata_o[31]; endproperty
  a_stopped: assert property (p_stopped) else $error("status bit set while idle");
  property p_angle; command_o != 5'h0b |-> rotate_angle_o == 2'h0; endproperty
  a_angle: assert property (p_angle) else $error("angle outside rotate");
  property p_pix; pix_valid_o |-> $past(busy_o); endproperty
  a_pix: assert property (p_pix) else $error("pixel while stopped");
  c_pix: cover property (pix_valid_o);
  c_quick: cover property (wr_dim && quick_reg);
  c_vsync: cover property (vsync_pulse_i && repeat_reg && command_o == 5'h0b);
endmodule
bind dce_engine dce_engine_properties i_dce_engine_properties (.clk_sys_i, .sys_rst_i,
  .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .vsync_pulse_i,
  .pix_valid_o, .busy_o, .command_o, .rotate_angle_o);

// file: tb/dce_engine_tb_top.sv
// Testbench for the drawing engine command block
`timescale 1ns/100ps
module dce_engine_tb_top;
  reg clk_sys_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [23:0] addr = 24'h0;
  reg [31:0] wd = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg vs = 1'b0;
  reg slow = 1'b0;
  reg [31:0] ctl = 32'h0;
  reg [31:0] got;
  reg [31:0] d;
  reg [23:0] first;
  reg [4:0] c;
  reg [31:0] ep;
  reg [31:0] es;
  reg [13:0] k1 = 14'h0;
  reg [13:0] k2 = 14'h0;
  reg [11:0] lx;
  reg [11:0] ly;
  integer miscompares = 0;
  integer checks = 0;
  integer npix = 0;
  integer i, w, h, le;
  wire [31:0] rdata, pat, src, dst, pdata;
  wire [11:0] cx, cy, px, py;
  wire rdy, sm, dm, pv, pwe, busy, wrap, pcol, vst, hm;
  wire [4:0] cmd;
  wire [1:0] pack, ang;
  always #12.5 clk_sys_i = ~clk_sys_i;
  dce_engine i_dce_engine (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd), .reg_rdata_o(rdata), .vsync_pulse_i(vs),
    .line_k1_i(k1), .line_k2_i(k2), .pat_pix_i(pat), .src_pix_i(src), .dst_pix_i(dst),
    .src_match_i(sm), .dst_match_i(dm), .pix_ready_i(rdy), .pix_valid_o(pv), .pix_we_o(pwe),
    .pix_x_o(px), .pix_y_o(py), .pix_data_o(pdata), .cur_x_o(cx), .cur_y_o(cy),
    .busy_o(busy), .command_o(cmd), .wrap_enable_o(wrap), .pattern_color_o(pcol),
    .vertical_stretch_enable_o(vst), .host_mono_o(hm), .mono_pack_o(pack),
    .rotate_angle_o(ang));
  dce_pix_model i_dce_pix_model (.clk_sys_i(clk_sys_i), .slow_i(slow), .cur_x_i(cx),
    .cur_y_i(cy), .pix_ready_o(rdy), .pat_o(pat), .src_o(src), .dst_o(dst),
    .src_match_o(sm), .dst_match_o(dm));
  function [31:0] ternary_raster_op(input [7:0] k, input [31:0] p, input [31:0] s, input [31:0] t);
    integer b;
    begin
      for (b = 0; b < 32; b = b + 1)
        ternary_raster_op[b] = k[{p[b], s[b], t[b]}];
    end
  endfunction
  function [31:0] binary_raster_op(input [3:0] k, input [31:0] s, input [31:0] t);
    integer b;
    begin
      for (b = 0; b < 32; b = b + 1)
        binary_raster_op[b] = k[{s[b], t[b]}];
    end
  endfunction
  // Block walk: rows of w pixels from the destination, X sense from bit 27
  function [23:0] blk_pos(input integer n);
    reg [11:0] bx;
    reg [11:0] by;
    begin
      bx = d[27:16] + (n % w);
      if (ctl[27])
        bx = d[27:16] - (n % w);
      by = d[11:0] + (n / w);
      blk_pos = {bx, by};
    end
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task wr32(input [23:0] a, input [31:0] v);
    begin
      @(negedge clk_sys_i);
      addr = a;
      wd = v;
      wr = 1'b1;
      @(negedge clk_sys_i);
      wr = 1'b0;
    end
  endtask
  task rd32(input [23:0] a);
    begin
      @(negedge clk_sys_i);
      addr = a;
      rd = 1'b1;
      @(negedge clk_sys_i);
      rd = 1'b0;
      got = rdata;
    end
  endtask
  // Looks for busy, then waits for it to drop under a bound
  task settle(input e);
    integer n;
    reg s;
    begin
      s = 1'b0;
      repeat (3) begin
        @(negedge clk_sys_i);
        s = s | (busy === 1'b1);
      end
      chk(s, e);
      n = 0;
      while (busy !== 1'b0 && n < 400) begin
        @(negedge clk_sys_i);
        n = n + 1;
      end
      if (n == 400) begin
        miscompares = miscompares + 1;
        complete_run;
      end
      repeat (2) @(negedge clk_sys_i);
    end
  endtask
  always @(negedge clk_sys_i) begin
    if (pv === 1'b1 && ctl[20:16] == 5'h01) begin
      if (npix == 0)
        first = {px, py};
      npix = npix + 1;
      ep = {px, py, 8'h5a};
      es = {py, 8'h3c, px};
      chk(pdata, ctl[15] ? binary_raster_op(ctl[3:0], ctl[14] ? ep : es, ~ep ^ {8'hc3, py, px})
        : ternary_raster_op(ctl[7:0], ep, es, ~ep ^ {8'hc3, py, px}));
      chk(pwe, !ctl[8] || ((ctl[9] ? py[0] : px[0]) != ctl[10]));
      chk({px, py}, blk_pos(npix - 1));
    end
    // Line model: major step always, minor step while the error term is not negative
    if (pv === 1'b1 && ctl[20:16] == 5'h07) begin
      npix = npix + 1;
      chk({px, py}, {lx, ly});
      chk(pwe, npix != w || ctl[21]);
      if (!ctl[26] || le >= 0)
        lx = ctl[25] ? lx - 12'h001 : lx + 12'h001;
      if (ctl[26] || le >= 0)
        ly = ctl[24] ? ly - 12'h001 : ly + 12'h001;
      le = (le < 0) ? le + $signed(k1) : le + $signed(k2);
    end
  end
  initial begin
    got = $urandom(60);
    repeat (3) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      rd32({i[21:0], 2'h0} + 24'h100004);
      chk(got, 32'h0);
    end
    wr32(24'h100004, 32'hffffffff);
    rd32(24'h100004);
    chk(got, 32'h9fffffff);
    chk(wrap, 1'b1);
    wr32(24'h100008, 32'hffffffff);
    rd32(24'h100008);
    chk(got, 32'h1fffffff);
    for (i = 0; i < 14; i = i + 1) begin
      c = (i < 13) ? i[4:0] : 5'h0f;
      d = ($urandom & 32'h6fe0ffff) | {11'h0, c, 16'h0};
      if (&d[13:12])
        d[12] = 1'b0;
      wr32(24'h10000c, d);
      rd32(24'h10000c);
      chk(got, d);
      chk({cmd, pcol, vst, hm, pack}, {c, d[30], d[23:22], d[13:12]});
      chk(ang, (c == 5'h0b) ? d[25:24] : 2'h0);
    end
    for (i = 0; i < 4; i = i + 1) begin
      w = (i == 0) ? 1 : 1 + $urandom % 3;
      h = 1 + $urandom % 3;
      slow = i[0];
      d = {8'h01, i[3:0], 20'h00020};
      wr32(24'h100004, d);
      wr32(24'h100008, {3'h0, w[12:0], h[15:0]});
      ctl = 32'h80010000 | ($urandom & 32'h0800c7ff);
      npix = 0;
      wr32(24'h10000c, ctl);
      settle(1'b1);
      chk(npix, w * h);
      chk(first, {d[27:16], d[11:0]});
      rd32(24'h100004);
      chk(got, d);
      chk(wrap, 1'b0);
      rd32(24'h10000c);
      chk(got[31], 1'b0);
    end
    ctl = 32'h100100f0;
    w = 2;
    wr32(24'h10000c, ctl);
    npix = 0;
    wr32(24'h100008, 32'h00020002);
    settle(1'b1);
    chk(npix, 4);
    ctl = 32'h000b08f0;
    for (i = 0; i < 2; i = i + 1) begin
      wr32(24'h10000c, ctl);
      @(negedge clk_sys_i);
      vs = 1'b1;
      @(negedge clk_sys_i);
      vs = 1'b0;
      settle(!i[0]);
      ctl[20:16] = 5'h01;
    end
    // Lines with major 4, minor 2: rising X major drops its end pixel, falling Y major keeps it
    k1 = 14'h0004;
    k2 = 14'h3ffc;
    for (i = 0; i < 2; i = i + 1) begin
      w = 4;
      lx = 12'h200;
      ly = 12'h100;
      // Error term one lower when X rises
      le = (i == 0) ? -1 : 0;
      wr32(24'h100004, 32'h02000100);
      wr32(24'h100008, {3'h0, 13'h0004, le[15:0]});
      ctl = (i == 0) ? 32'ha0070000 : 32'ha7270000;
      npix = 0;
      wr32(24'h10000c, ctl);
      settle(1'b1);
      chk(npix, w);
      rd32(24'h100004);
      chk(got, {4'h0, lx, 16'h0100});
    end
    complete_run;
  end
endmodule
